// file: verilog/sensor_cfg.svh
`ifndef SENSOR_CFG_SVH
`define SENSOR_CFG_SVH
`define CLK_PERIOD_NS 5
`define LINK_PERIOD_PS 12000
`define T_SPIKE_PS 50000
`define FILT_CYC ((`T_SPIKE_PS + `LINK_PERIOD_PS - 1) / `LINK_PERIOD_PS)
`define T_START_NS 15000000
`define T_TEMP14_NS 6350000
`define T_TEMP11_NS 3650000
`define T_HUM14_NS 6500000
`define T_HUM11_NS 3850000
`define T_HUM8_NS 2500000
`define START_CYC (`T_START_NS / `CLK_PERIOD_NS)
`define TEMP14_CYC (`T_TEMP14_NS / `CLK_PERIOD_NS)
`define TEMP11_CYC (`T_TEMP11_NS / `CLK_PERIOD_NS)
`define HUM14_CYC (`T_HUM14_NS / `CLK_PERIOD_NS)
`define HUM11_CYC (`T_HUM11_NS / `CLK_PERIOD_NS)
`define HUM8_CYC (`T_HUM8_NS / `CLK_PERIOD_NS)
`define ADDR_BASE 5'h10
`define PTR_TEMP 8'h00
`define PTR_HUM 8'h01
`define PTR_CFG 8'h02
`define PTR_SER_FIRST 8'hFB
`define PTR_SER_LAST 8'hFF
`define CFG_SRST 15
`define CFG_HEATER_ENABLE 13
`define CFG_MODE 12
`define CFG_SUPLO 11
`define CFG_TRES 10
`define CFG_HRES_HI 9
`define CFG_HRES_LO 8
`define CFG_RESET 16'h1000
`define HRES_11 2'h1
`define HRES_8 2'h2
`endif

// file: verilog/sensor_pkg.sv
package sensor_pkg;
    typedef enum logic [9:0] {
        S_IDLE = 10'h001,
        S_ADDR = 10'h002,
        S_AACK = 10'h004,
        S_PTR = 10'h008,
        S_PACK = 10'h010,
        S_WDAT = 10'h020,
        S_WACK = 10'h040,
        S_RDAT = 10'h080,
        S_RACK = 10'h100,
        S_IGN = 10'h200
    } bus_state_t;
    typedef enum logic [2:0] {
        M_SLEEP = 3'h1,
        M_TEMP = 3'h2,
        M_HUM = 3'h4
    } meas_state_t;
endpackage

// file: verilog/spike_filter.sv
`timescale 1ns/1ps
`include "sensor_cfg.svh"
module spike_filter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic din,
    output logic dout
);
    logic [1:0] sync_r;
    logic [2:0] cnt_r;

    // Output follows only after FILT_CYC+1 equal samples, so a 50 ns spike never gets through
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_r <= 2'h3;
            cnt_r <= 3'h0;
            dout <= 1'b1;
        end
        else if (ce)
        begin
            sync_r <= {sync_r[0], din};
            if (sync_r[1] == dout)
                cnt_r <= 3'h0;
            else if (cnt_r == 3'(`FILT_CYC))
            begin
                dout <= sync_r[1];
                cnt_r <= 3'h0;
            end
            else
                cnt_r <= cnt_r + 3'h1;
        end
    end

    property p_spike_reject;
        @(posedge clk) disable iff (!rst_n || !ce)
        $changed(dout) |-> ($past(sync_r[1], 1) == dout) && ($past(sync_r[1], 6) == dout);
    endproperty
    a_spike_reject: assert property (p_spike_reject)
        else $error("filter output changed after a short pulse");
endmodule

// file: verilog/humidity_temp_sensor_i2c_slave.sv
`timescale 1ns/1ps
`include "sensor_cfg.svh"
module humidity_temp_sensor_i2c_slave
    import sensor_pkg::*;
#(
    parameter int unsigned START_CYC = `START_CYC,
    parameter int unsigned TEMP14_CYC = `TEMP14_CYC,
    parameter int unsigned TEMP11_CYC = `TEMP11_CYC,
    parameter int unsigned HUM14_CYC = `HUM14_CYC,
    parameter int unsigned HUM11_CYC = `HUM11_CYC,
    parameter int unsigned HUM8_CYC = `HUM8_CYC,
    parameter logic [15:0] SERIAL_FB = 16'h1234, // Arbitrary value
    parameter logic [15:0] SERIAL_FC = 16'h5678, // Arbitrary value
    parameter logic [15:0] SERIAL_FD = 16'h9A00, // Arbitrary value
    parameter logic [15:0] SERIAL_FE = 16'h0042, // Arbitrary value
    parameter logic [15:0] SERIAL_FF = 16'h0100 // Arbitrary value
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic link_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic addr_select_hi,
    input wire logic addr_select_lo,
    input wire logic supply_below_min,
    input wire logic [13:0] temp_sample,
    input wire logic [13:0] hum_sample,
    output logic conversion_done_n,
    output logic heater_on,
    output logic device_ready
);
    function automatic logic is_serial(input logic [7:0] p);
        return p >= `PTR_SER_FIRST;
    endfunction

    function automatic logic reg_valid(input logic [7:0] p);
        return (p <= `PTR_CFG) || is_serial(p);
    endfunction

    function automatic logic read_only(input logic [7:0] p);
        return p != `PTR_CFG;
    endfunction

    function automatic logic [15:0] word_of(input logic [7:0] p, input logic [15:0] t,
                                            input logic [15:0] h, input logic [15:0] c);
        logic [15:0] w;
        w = 16'h0000;
        unique case (p)
            `PTR_TEMP: w = t;
            `PTR_HUM: w = h;
            `PTR_CFG: w = c;
            8'hFB: w = SERIAL_FB;
            8'hFC: w = SERIAL_FC;
            8'hFD: w = SERIAL_FD;
            8'hFE: w = SERIAL_FE;
            8'hFF: w = SERIAL_FF;
            default: w = 16'h0000;
        endcase
        return w;
    endfunction

    // Reset release, one copy per domain
    logic [1:0] rst_c_r;
    logic [1:0] rst_l_r;
    logic rst_n_c;
    logic rst_n_l;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rst_c_r <= 2'h0;
        else
            rst_c_r <= {rst_c_r[0], 1'b1};
    end
    always_ff @(posedge link_clk or negedge rst_b)
    begin
        if (!rst_b)
            rst_l_r <= 2'h0;
        else
            rst_l_r <= {rst_l_r[0], 1'b1};
    end
    assign rst_n_c = rst_c_r[1];
    assign rst_n_l = rst_l_r[1];

    // ---------------- Link domain ----------------
    logic [1:0] ce_l_s;
    logic [1:0] hi_s;
    logic [1:0] lo_s;
    logic [1:0] rdy_s;
    logic [1:0] sfl_s;
    logic [2:0] d_s;
    logic ce_l;
    logic scl_f;
    logic sda_f;
    logic scl_q;
    logic sda_q;
    bus_state_t st_r;
    logic [2:0] cnt_r;
    logic [7:0] shift_r;
    logic [7:0] ptr_r;
    logic [7:0] tx_r;
    logic [7:0] wr_hi_r;
    logic [1:0] own_lo_r;
    logic drv_r;
    logic arm_r;
    logic rw_r;
    logic byte_hi_r;
    logic rd_lo_r;
    logic word_r;
    logic heater_enable_r;
    logic mode_r;
    logic tres_r;
    logic [1:0] hres_r;
    logic fresh_t_r;
    logic fresh_h_r;
    logic trig_tgl_r;
    logic [1:0] kind_r;
    logic [15:0] temp_l_r;
    logic [15:0] hum_l_r;
    logic [15:0] temp_res_r;
    logic [15:0] hum_res_r;
    logic supply_flag_r;
    logic done_tgl_r;
    logic ready_r;

    always_ff @(posedge link_clk or negedge rst_n_l)
    begin
        if (!rst_n_l)
            ce_l_s <= 2'h0;
        else
            ce_l_s <= {ce_l_s[0], ce};
    end
    assign ce_l = ce_l_s[1];

    spike_filter u_scl_filt (.clk(link_clk), .rst_n(rst_n_l), .ce(ce_l),
        .din(scl_in), .dout(scl_f));
    spike_filter u_sda_filt (.clk(link_clk), .rst_n(rst_n_l), .ce(ce_l),
        .din(sda_in), .dout(sda_f));

    always_ff @(posedge link_clk or negedge rst_n_l)
    begin
        if (!rst_n_l)
        begin
            {hi_s, lo_s, rdy_s, sfl_s} <= 8'h00;
            d_s <= 3'h0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else if (ce_l)
        begin
            hi_s <= {hi_s[0], addr_select_hi};
            lo_s <= {lo_s[0], addr_select_lo};
            rdy_s <= {rdy_s[0], ready_r};
            sfl_s <= {sfl_s[0], supply_flag_r};
            d_s <= {d_s[1:0], done_tgl_r};
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    wire ready_l = rdy_s[1];
    wire done_ev = d_s[1] ^ d_s[2];
    wire start_c = scl_f && scl_q && sda_q && !sda_f;
    wire stop_c = scl_f && scl_q && !sda_q && sda_f;
    wire rise = scl_f && !scl_q;
    wire fall = !scl_f && scl_q;
    wire [7:0] rx_byte = {shift_r[6:0], sda_f};
    wire byte_end = rise && (cnt_r == 3'h7);
    wire addr_hit = rx_byte[7:1] == {`ADDR_BASE, own_lo_r};
    wire res_fresh = (ptr_r == `PTR_TEMP) ? fresh_t_r : (ptr_r == `PTR_HUM) ? fresh_h_r : 1'b1;
    wire rd_ok = reg_valid(ptr_r) && (ready_l ? res_fresh : is_serial(ptr_r));
    wire addr_take = addr_hit && (!rx_byte[0] || rd_ok);
    wire ptr_ok = reg_valid(rx_byte) && (ready_l || is_serial(rx_byte));
    wire wr_ok = !read_only(ptr_r) && ready_l;
    wire trig_now = (st_r == S_PTR) && byte_end && ptr_ok && ready_l && (rx_byte <= `PTR_HUM);
    wire [1:0] trig_kind = (rx_byte == `PTR_HUM) ? 2'h2 : (mode_r ? 2'h3 : 2'h1);
    wire cfg_commit = (st_r == S_WDAT) && byte_end && wr_ok && byte_hi_r;
    wire [15:0] cfg_word = {2'h0, heater_enable_r, mode_r, sfl_s[1], tres_r, hres_r, 8'h00};
    wire [15:0] cur_word = word_of(ptr_r, temp_l_r, hum_l_r, cfg_word);
    wire [7:0] nxt_ptr = ((word_r || rd_lo_r) && mode_r && ptr_r == `PTR_TEMP) ? `PTR_HUM : ptr_r;
    wire [15:0] nxt_word = word_of(nxt_ptr, temp_l_r, hum_l_r, cfg_word);
    wire [7:0] nxt_byte = rd_lo_r ? nxt_word[15:8] : nxt_word[7:0];

    assign sda_out = 1'b0;
    assign sda_oe_n = !drv_r;

    always_ff @(posedge link_clk or negedge rst_n_l)
    begin
        if (!rst_n_l)
        begin
            st_r <= S_IDLE;
            {cnt_r, shift_r, ptr_r, tx_r, wr_hi_r, own_lo_r} <= 37'h0;
            {drv_r, arm_r, rw_r, byte_hi_r, rd_lo_r, word_r} <= 6'h00;
        end
        else if (ce_l)
        begin
            if (start_c)
            begin
                st_r <= S_ADDR;
                cnt_r <= 3'h0;
                own_lo_r <= {hi_s[1], lo_s[1]};
                {drv_r, arm_r, byte_hi_r, rd_lo_r, word_r} <= 5'h00;
            end
            else if (stop_c)
            begin
                st_r <= S_IDLE;
                drv_r <= 1'b0;
            end
            else
            begin
                unique case (st_r)
                    S_ADDR, S_PTR, S_WDAT:
                        if (rise)
                        begin
                            shift_r <= rx_byte;
                            cnt_r <= cnt_r + 3'h1;
                            if (byte_end && st_r == S_ADDR)
                            begin
                                rw_r <= rx_byte[0];
                                st_r <= addr_take ? S_AACK : S_IGN;
                            end
                            if (byte_end && st_r == S_PTR)
                            begin
                                st_r <= ptr_ok ? S_PACK : S_IGN;
                                if (ptr_ok)
                                    ptr_r <= rx_byte;
                            end
                            if (byte_end && st_r == S_WDAT)
                            begin
                                st_r <= wr_ok ? S_WACK : S_IGN;
                                byte_hi_r <= !byte_hi_r;
                                wr_hi_r <= rx_byte;
                            end
                        end
                    S_AACK, S_PACK, S_WACK:
                        if (fall && !arm_r)
                        begin
                            drv_r <= 1'b1;
                            arm_r <= 1'b1;
                        end
                        else if (fall)
                        begin
                            arm_r <= 1'b0;
                            cnt_r <= 3'h0;
                            drv_r <= 1'b0;
                            st_r <= (st_r == S_AACK) ? S_PTR : S_WDAT;
                            if (st_r == S_AACK && rw_r)
                            begin
                                st_r <= S_RDAT;
                                tx_r <= cur_word[15:8];
                                drv_r <= !cur_word[15];
                            end
                        end
                    S_RDAT:
                        if (fall)
                        begin
                            cnt_r <= cnt_r + 3'h1;
                            tx_r <= {tx_r[6:0], 1'b0};
                            drv_r <= (cnt_r == 3'h7) ? 1'b0 : !tx_r[6];
                            if (cnt_r == 3'h7)
                                st_r <= S_RACK;
                        end
                    S_RACK:
                        if (rise && sda_f)
                            st_r <= S_IGN;
                        else if (rise)
                            arm_r <= 1'b1;
                        else if (fall && arm_r)
                        begin
                            arm_r <= 1'b0;
                            rd_lo_r <= !rd_lo_r;
                            word_r <= word_r || rd_lo_r;
                            tx_r <= nxt_byte;
                            drv_r <= !nxt_byte[7];
                            cnt_r <= 3'h0;
                            st_r <= S_RDAT;
                        end
                    S_IDLE, S_IGN:
                        drv_r <= 1'b0;
                    default:
                        st_r <= S_IGN;
                endcase
            end
        end
    end

    // Config, result freshness and trigger handoff
    always_ff @(posedge link_clk or negedge rst_n_l)
    begin
        if (!rst_n_l)
        begin
            {heater_enable_r, mode_r, tres_r, hres_r} <= 5'h08;
            {fresh_t_r, fresh_h_r, trig_tgl_r, kind_r} <= 5'h00;
            temp_l_r <= 16'h0000;
            hum_l_r <= 16'h0000;
        end
        else if (ce_l)
        begin
            if (cfg_commit && wr_hi_r[`CFG_SRST - 8])
                {heater_enable_r, mode_r, tres_r, hres_r} <= 5'h08;
            else if (cfg_commit)
            begin
                heater_enable_r <= wr_hi_r[`CFG_HEATER_ENABLE - 8];
                mode_r <= wr_hi_r[`CFG_MODE - 8];
                tres_r <= wr_hi_r[`CFG_TRES - 8];
                hres_r <= wr_hi_r[`CFG_HRES_HI - 8:`CFG_HRES_LO - 8];
            end
            if (trig_now)
            begin
                trig_tgl_r <= !trig_tgl_r;
                kind_r <= trig_kind;
            end
            // A completion arriving with a new trigger still marks its result
            fresh_t_r <= (fresh_t_r && !(trig_now && trig_kind[0])) || (done_ev && kind_r[0]);
            fresh_h_r <= (fresh_h_r && !(trig_now && trig_kind[1])) || (done_ev && kind_r[1]);
            if (done_ev)
            begin
                temp_l_r <= temp_res_r;
                hum_l_r <= hum_res_r;
            end
        end
    end

    // ---------------- Core domain ----------------
    logic [2:0] t_s;
    logic [1:0] sup_s;
    logic [21:0] start_cnt_r;
    logic [21:0] timer_r;
    meas_state_t m_st_r;
    logic [1:0] mkind_r;
    logic tres_lat_r;
    logic [1:0] hres_lat_r;
    logic [2:0] sup_init_r;
    logic done_n_r;
    logic heater_r;

    wire trig_ev = t_s[1] ^ t_s[2];
    wire [21:0] temp_lim = tres_lat_r ? 22'(TEMP11_CYC) : 22'(TEMP14_CYC);
    wire [21:0] hum_lim = (hres_lat_r == `HRES_11) ? 22'(HUM11_CYC) :
                          (hres_lat_r == `HRES_8) ? 22'(HUM8_CYC) : 22'(HUM14_CYC);
    wire [21:0] phase_lim = (m_st_r == M_TEMP) ? temp_lim : hum_lim;
    wire phase_end = (m_st_r != M_SLEEP) && (timer_r == phase_lim - 22'h1);

    assign conversion_done_n = done_n_r;
    assign heater_on = heater_r;
    assign device_ready = ready_r;

    always_ff @(posedge clk or negedge rst_n_c)
    begin
        if (!rst_n_c)
        begin
            t_s <= 3'h0;
            sup_s <= 2'h0;
            start_cnt_r <= 22'h000000;
            ready_r <= 1'b0;
            sup_init_r <= 3'h7;
            supply_flag_r <= 1'b0;
        end
        else if (ce)
        begin
            t_s <= {t_s[1:0], trig_tgl_r};
            sup_s <= {sup_s[0], supply_below_min};
            // Keep refreshing until the synchroniser holds the real pin level
            sup_init_r <= {sup_init_r[1:0], 1'b0};
            if (sup_init_r[2] || (trig_ev && ready_r))
                supply_flag_r <= sup_s[1];
            if (!ready_r)
                start_cnt_r <= start_cnt_r + 22'h1;
            if (!ready_r && start_cnt_r == 22'(START_CYC) - 22'h1)
                ready_r <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n_c)
    begin
        if (!rst_n_c)
        begin
            m_st_r <= M_SLEEP;
            {timer_r, mkind_r, tres_lat_r, hres_lat_r} <= 27'h0;
            {done_n_r, heater_r, done_tgl_r} <= 3'h4;
            temp_res_r <= 16'h0000;
            hum_res_r <= 16'h0000;
        end
        else if (ce)
        begin
            timer_r <= timer_r + 22'h1;
            if (trig_ev && ready_r)
            begin
                // New trigger restarts, which also aborts a running one
                m_st_r <= kind_r[0] ? M_TEMP : M_HUM;
                mkind_r <= kind_r;
                tres_lat_r <= tres_r;
                hres_lat_r <= hres_r;
                heater_r <= heater_enable_r;
                timer_r <= 22'h000000;
                done_n_r <= 1'b1;
            end
            else if (phase_end)
            begin
                timer_r <= 22'h000000;
                if (m_st_r == M_TEMP)
                    temp_res_r <= {temp_sample, 2'h0};
                else
                    hum_res_r <= {hum_sample, 2'h0};
                if (m_st_r == M_TEMP && mkind_r[1])
                    m_st_r <= M_HUM;
                else
                begin
                    m_st_r <= M_SLEEP;
                    heater_r <= 1'b0;
                    done_n_r <= 1'b0;
                    done_tgl_r <= !done_tgl_r;
                end
            end
        end
    end

    property p_heater_sleep;
        @(posedge clk) disable iff (!rst_n_c)
        (m_st_r == M_SLEEP) |-> !heater_on;
    endproperty
    a_heater_sleep: assert property (p_heater_sleep)
        else $error("heater on while asleep");

    property p_done_then_sleep;
        @(posedge clk) disable iff (!rst_n_c)
        $fell(conversion_done_n) |-> (m_st_r == M_SLEEP) && ($past(m_st_r) != M_SLEEP);
    endproperty
    a_done_then_sleep: assert property (p_done_then_sleep)
        else $error("done without ending a measurement");

    property p_no_measure_early;
        @(posedge clk) disable iff (!rst_n_c)
        !ready_r |-> (m_st_r == M_SLEEP) && conversion_done_n;
    endproperty
    a_no_measure_early: assert property (p_no_measure_early)
        else $error("measurement before start-up ended");

    property p_trigger_starts;
        @(posedge clk) disable iff (!rst_n_c)
        (ce && trig_ev && ready_r) |=> (m_st_r != M_SLEEP) && conversion_done_n;
    endproperty
    a_trigger_starts: assert property (p_trigger_starts)
        else $error("trigger did not start a measurement");

    property p_foreign_addr;
        @(posedge link_clk) disable iff (!rst_n_l)
        (ce_l && st_r == S_ADDR && byte_end && !addr_hit) |=> (st_r == S_IGN) && sda_oe_n;
    endproperty
    a_foreign_addr: assert property (p_foreign_addr)
        else $error("foreign address not ignored");

    property p_unused_ptr;
        @(posedge link_clk) disable iff (!rst_n_l)
        (ce_l && st_r == S_PTR && byte_end && !reg_valid(rx_byte))
        |=> (st_r == S_IGN) ##1 sda_oe_n;
    endproperty
    a_unused_ptr: assert property (p_unused_ptr)
        else $error("unused pointer acknowledged");

    property p_ro_write;
        @(posedge link_clk) disable iff (!rst_n_l)
        (ce_l && st_r == S_WDAT && byte_end && read_only(ptr_r)) |=> st_r == S_IGN;
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("write to read-only register acknowledged");

    property p_ignore_quiet;
        @(posedge link_clk) disable iff (!rst_n_l)
        (st_r == S_IGN) |-> sda_oe_n;
    endproperty
    a_ignore_quiet: assert property (p_ignore_quiet)
        else $error("data line driven while ignoring");

    property p_read_keeps_ptr;
        @(posedge link_clk) disable iff (!rst_n_l)
        (st_r == S_RDAT || st_r == S_RACK) |=> $stable(ptr_r);
    endproperty
    a_read_keeps_ptr: assert property (p_read_keeps_ptr)
        else $error("pointer changed by a read");

    property p_startup_serial;
        @(posedge link_clk) disable iff (!rst_n_l)
        (ce_l && st_r == S_ADDR && byte_end && rx_byte[0] && !ready_l && !is_serial(ptr_r))
        |=> st_r == S_IGN;
    endproperty
    a_startup_serial: assert property (p_startup_serial)
        else $error("non-serial read served during start-up");
endmodule

// file: tb/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // Quarter bit time; far above the input filter latency
    localparam int Q = 300;
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic start();
        sda_low = 1'b0;
        #Q scl = 1'b1;
        #Q sda_low = 1'b1;
        #Q scl = 1'b0;
        #Q;
    endtask
    task automatic stop();
        sda_low = 1'b1;
        #Q scl = 1'b1;
        #Q sda_low = 1'b0;
        #Q;
    endtask
    task automatic bitx(input logic b, output logic s);
        sda_low = !b;
        #Q scl = 1'b1;
        #Q s = sda;
        #Q scl = 1'b0;
        #Q;
    endtask
    task automatic xfer(input logic [7:0] w, input logic m, output logic [7:0] r, output logic a);
        logic s;
        for (int i = 7; i >= 0; i--)
            bitx(w[i], r[i]);
        bitx(m, s);
        a = !s;
    endtask
endmodule

// file: tb/humidity_temp_sensor_i2c_slave_tb_top.sv
`timescale 1ns/1ps
module humidity_temp_sensor_i2c_slave_tb_top;
    logic clk = 0, link_clk = 0, rst_b = 0, ce = 1, sel_hi = 1, sel_lo = 0, low_sup = 1;
    logic [13:0] t_smp = 14'h2A5C, h_smp = 14'h1234;
    logic scl, m_low, sda_out, sda_oe_n, done_n, heater_enable, rdy, a, b;
    logic [7:0] r, hi;
    int error_cnt = 0, n_tests = 0;
    // Pull-up: released line reads high
    wire sda = !(m_low || !sda_oe_n);
    initial forever #2.5 clk = ~clk;
    initial
    begin
        #3.7;
        forever #6 link_clk = ~link_clk;
    end
    humidity_temp_sensor_i2c_slave #(.START_CYC(20000), .TEMP14_CYC(4000))
        humidity_temp_sensor_i2c_slave_i (.clk(clk), .rst_b(rst_b), .ce(ce),
        .link_clk(link_clk), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .addr_select_hi(sel_hi), .addr_select_lo(sel_lo),
        .supply_below_min(low_sup), .temp_sample(t_smp), .hum_sample(h_smp),
        .conversion_done_n(done_n), .heater_on(heater_enable), .device_ready(rdy));
    i2c_master_model i2c_master_model_i (.scl(scl), .sda_low(m_low), .sda(sda));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        n_tests++;
        if (s !== e)
        begin
            $display("BAD %s exp %h got %h", n, e, s);
            error_cnt++;
        end
    endtask
    task automatic wr(input logic [7:0] w, output logic k);
        i2c_master_model_i.xfer(w, 1'b1, r, k);
    endtask
    task automatic t_early();
        chk("not ready", 16'h0, rdy);
        chk("sda out", 16'h0, sda_out);
        i2c_master_model_i.start();
        wr(8'h85, a);
        chk("early read", 16'h0, a);
        i2c_master_model_i.start();
        wr(8'h84, a);
        chk("addr ack", 16'h1, a);
        wr(8'h02, a);
        chk("early cfg ptr", 16'h0, a);
        i2c_master_model_i.start();
        wr(8'h84, a);
        wr(8'hFB, a);
        chk("early serial ptr", 16'h1, a);
        i2c_master_model_i.start();
        wr(8'h80, a);
        chk("foreign addr", 16'h0, a);
        i2c_master_model_i.stop();
    endtask
    task automatic t_refuse();
        i2c_master_model_i.start();
        wr(8'h84, a);
        wr(8'h05, a);
        chk("unused ptr", 16'h0, a);
        i2c_master_model_i.start();
        wr(8'h84, a);
        wr(8'hFB, a);
        wr(8'h11, a);
        chk("ro data", 16'h0, a);
        i2c_master_model_i.stop();
    endtask
    task automatic rd16(output logic [15:0] v);
        i2c_master_model_i.start();
        wr(8'h85, a);
        i2c_master_model_i.xfer(8'hFF, 1'b0, hi, a);
        i2c_master_model_i.xfer(8'hFF, 1'b1, r, a);
        i2c_master_model_i.stop();
        v = {hi, r};
    endtask
    task automatic t_meas();
        logic [15:0] v;
        i2c_master_model_i.start();
        wr(8'h84, a);
        wr(8'h02, a);
        wr(8'h20, a);
        wr(8'h00, b);
        chk("cfg data ack", 16'h1, b);
        i2c_master_model_i.start();
        wr(8'h84, a);
        wr(8'h02, a);
        rd16(v);
        chk("cfg", 16'h2800, v);
        i2c_master_model_i.start();
        wr(8'h84, a);
        wr(8'h00, a);
        i2c_master_model_i.start();
        wr(8'h85, a);
        chk("stale read", 16'h0, a);
        i2c_master_model_i.stop();
        #1000;
        chk("measuring", 16'h3, {done_n, heater_enable});
        for (int i = 0; i < 5000 && done_n; i++)
            @(negedge clk);
        chk("done", 16'h0, {done_n, heater_enable});
        rd16(v);
        chk("temp", {t_smp, 2'b00}, v);
    endtask
    task automatic report_and_stop();
        if (error_cnt == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        repeat (40) @(negedge clk);
        t_early();
        for (int i = 0; i < 30000 && !rdy; i++)
            @(negedge clk);
        chk("ready", 16'h1, rdy);
        t_refuse();
        t_meas();
        report_and_stop();
    end
    initial
    begin
        #500000;
        error_cnt++;
        report_and_stop();
    end
endmodule
